// [verilog/cbr_regfile.sv]
// Base register file: general registers, instruction pointer and flags word, AXI4-Lite reached.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_regfile (
    input  wire logic         core_clk_i,
    input  wire logic         rstn_i,
    input  wire logic         clk_en_i,
    input  wire logic [11:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [11:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              v86_active_o,
    output logic              debug_suppress_o,
    output logic              fault_valid_o,
    output logic [7:0]        fault_vector_o,
    output logic [31:0]       fault_error_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [31:0]        gp_r [8];
    logic [31:0]        next_instruction_offset_r;
    logic [31:0]        flags_r;
    logic [1:0]         cpl_r;
    logic               prot_mode_r;
    logic               sys_ref_r;
    cbr_pkg::cbr_size_t ref_size_r;
    logic [31:0]        image_r;
    logic [31:0]        addr_r;
    logic [31:0]        result_r;
    cbr_pkg::cbr_fault_t fault_r;
    logic [31:0]        fault_err_r;
    logic               io_ok_r;
    logic               sys_ok_r;

    // Write channel latches so address and data may arrive in either order.
    logic        aw_have_r;
    logic        w_have_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic        bresp_err_r;
    cbr_pkg::cbr_rd_state_t rd_state_r;
    logic [31:0] rdata_r;
    logic        rresp_err_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Merge a word under byte strobes.
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : strb_merge

    // Force the undefined bits to their stored pattern.
    function automatic logic [31:0] flags_clean(input logic [31:0] v);
        return (v & `CBR_FLAGS_KEEP) | `CBR_FLAGS_FORCE;
    endfunction : flags_clean

    // Decide whether a reference of this size at this address is misaligned.
    function automatic logic misaligned(input logic [31:0] a, input cbr_pkg::cbr_size_t s);
        case (s)
            cbr_pkg::CBR_SZ_WORD:  return a[0];
            cbr_pkg::CBR_SZ_DWORD: return |a[1:0];
            cbr_pkg::CBR_SZ_QWORD: return |a[2:0];
            default:               return 1'b0;
        endcase
    endfunction : misaligned

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes and command decode.
    logic        wr_fire;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_gp;
    logic        wr_cmd;
    logic        wr_hit;
    cbr_pkg::cbr_op_t op;
    logic [2:0]  op_reg;
    logic [1:0]  cpl_eff;
    logic        can_io_privilege_field;
    logic [31:0] pop_v;

    // A write fires once both halves are held and no response is pending.
    always_comb begin
        wr_fire = aw_have_r && w_have_r && !bvalid_r;
        wr_addr = aw_addr_r;
        wr_data = w_data_r;
        wr_strb = w_strb_r;
        wr_gp   = wr_fire && (wr_addr < `CBR_OFF_IP);
        wr_cmd  = wr_fire && (wr_addr == `CBR_OFF_CMD);
        wr_hit  = wr_gp || wr_addr == `CBR_OFF_IP || wr_addr == `CBR_OFF_FLAGS ||
                  wr_addr == `CBR_OFF_CTRL || wr_addr == `CBR_OFF_CMD ||
                  wr_addr == `CBR_OFF_IMAGE || wr_addr == `CBR_OFF_ADDR;
        op      = wr_cmd ? cbr_pkg::cbr_op_t'(wr_data[3:0]) : cbr_pkg::CBR_OP_NONE;
        op_reg  = wr_data[6:4];
        cpl_eff = sys_ref_r ? `CBR_CPL_SYS : cpl_r;
        can_io_privilege_field = (cpl_r <= flags_r[`CBR_IO_PRIVILEGE_FIELD_HI:`CBR_IO_PRIVILEGE_FIELD_LO]);
        pop_v    = flags_clean(image_r);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (clk_en_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (clk_en_i) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Ready stays high while the slot is empty.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else if (clk_en_i) begin
            s_axi_awready <= !(aw_have_r || (s_axi_awvalid && s_axi_awready)) || wr_fire;
            s_axi_wready  <= !(w_have_r || (s_axi_wvalid && s_axi_wready)) || wr_fire;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bvalid_r    <= 1'b0;
            bresp_err_r <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_fire) begin
                bvalid_r    <= 1'b1;
                bresp_err_r <= !wr_hit;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_err_r ? `CBR_RESP_SLVERR : `CBR_RESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////////
    // General registers with 32 and 16 views, and byte views on the first four only.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 8; i++) begin
                gp_r[i] <= 32'h0000_0000;
            end
        end else if (clk_en_i) begin
            if (wr_gp) begin
                gp_r[wr_addr[4:2]] <= strb_merge(gp_r[wr_addr[4:2]], wr_data, wr_strb);
            end else if (op == cbr_pkg::CBR_OP_GP32) begin
                gp_r[op_reg] <= result_r;
            end else if (op == cbr_pkg::CBR_OP_GP16) begin
                gp_r[op_reg][15:0] <= result_r[15:0];
            end else if (op == cbr_pkg::CBR_OP_GP8L && !op_reg[2]) begin
                gp_r[op_reg][7:0] <= result_r[7:0];
            end else if (op == cbr_pkg::CBR_OP_GP8H && !op_reg[2]) begin
                gp_r[op_reg][15:8] <= result_r[7:0];
            end else if (op == cbr_pkg::CBR_OP_TASKSW) begin
                gp_r[op_reg] <= result_r;
            end
        end
    end

    // Instruction pointer; a task switch also loads it from the incoming context.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            next_instruction_offset_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (wr_fire && wr_addr == `CBR_OFF_IP) begin
                next_instruction_offset_r <= strb_merge(next_instruction_offset_r, wr_data,
                                                        wr_strb);
            end else if (op == cbr_pkg::CBR_OP_SETIP || op == cbr_pkg::CBR_OP_TASKSW) begin
                next_instruction_offset_r <= addr_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags word updates.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_r <= `CBR_FLAGS_FORCE;
        end else if (clk_en_i) begin
            case (op)
                cbr_pkg::CBR_OP_POP_FLAGS_INSTR, cbr_pkg::CBR_OP_INTERRUPT_RETURN_INSTR: begin
                    flags_r <= pop_v;
                    flags_r[`CBR_BIT_RF] <= pop_v[`CBR_BIT_RF];
                    flags_r[`CBR_BIT_NT] <= pop_v[`CBR_BIT_NT];
                    if (!can_io_privilege_field) begin
                        flags_r[`CBR_BIT_IF] <= flags_r[`CBR_BIT_IF];
                    end
                    if (cpl_r != `CBR_CPL_SYS) begin
                        flags_r[`CBR_IO_PRIVILEGE_FIELD_HI:`CBR_IO_PRIVILEGE_FIELD_LO] <=
                            flags_r[`CBR_IO_PRIVILEGE_FIELD_HI:`CBR_IO_PRIVILEGE_FIELD_LO];
                    end
                    if (op == cbr_pkg::CBR_OP_POP_FLAGS_INSTR || cpl_r != `CBR_CPL_SYS || !prot_mode_r) begin
                        flags_r[`CBR_BIT_VM] <= flags_r[`CBR_BIT_VM];
                    end
                end
                cbr_pkg::CBR_OP_TASKSW: begin
                    flags_r <= pop_v;
                    if (!prot_mode_r) begin
                        flags_r[`CBR_BIT_VM] <= 1'b0;
                    end
                end
                cbr_pkg::CBR_OP_RETIRE: begin
                    flags_r[`CBR_BIT_RF] <= 1'b0;
                end
                default: begin
                    if (wr_fire && wr_addr == `CBR_OFF_FLAGS && cpl_r == `CBR_CPL_SYS) begin
                        flags_r <= flags_clean(strb_merge(flags_r, wr_data, wr_strb));
                    end
                end
            endcase
        end
    end

    // Mode and privilege control written by the execution logic.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpl_r       <= `CBR_CPL_SYS;
            prot_mode_r <= 1'b0;
            sys_ref_r   <= 1'b0;
            ref_size_r  <= cbr_pkg::CBR_SZ_BYTE;
            image_r     <= 32'h0000_0000;
            addr_r      <= 32'h0000_0000;
        end else if (clk_en_i && wr_fire) begin
            if (wr_addr == `CBR_OFF_CTRL) begin
                cpl_r       <= wr_data[1:0];
                prot_mode_r <= wr_data[2];
                sys_ref_r   <= wr_data[3];
                ref_size_r  <= cbr_pkg::cbr_size_t'(wr_data[5:4]);
            end
            if (wr_addr == `CBR_OFF_IMAGE) begin
                image_r <= wr_data;
            end
            if (wr_addr == `CBR_OFF_ADDR) begin
                addr_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stored flag images, fault detection and privilege checks.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (op == cbr_pkg::CBR_OP_PUSH_FLAGS_INSTR) begin
                result_r <= flags_clean(flags_r) & ~(32'h1 << `CBR_BIT_VM);
            end else if (op == cbr_pkg::CBR_OP_INTSAVE) begin
                result_r <= flags_clean(flags_r);
            end else if (wr_fire && wr_addr == `CBR_OFF_IMAGE) begin
                result_r <= wr_data;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_r     <= '0;
            fault_err_r <= 32'h0000_0000;
            io_ok_r     <= 1'b0;
            sys_ok_r    <= 1'b0;
        end else if (clk_en_i) begin
            if (op == cbr_pkg::CBR_OP_MEMREF) begin
                // Only the instruction's effective address is checked.
                fault_r.valid  <= flags_r[`CBR_BIT_AC] && cpl_eff == `CBR_CPL_USER &&
                                  misaligned(addr_r, ref_size_r);
                fault_r.vector <= `CBR_VEC_ALIGN;
                fault_err_r    <= `CBR_ERR_ALIGN;
            end else if (op == cbr_pkg::CBR_OP_IOCHK) begin
                io_ok_r        <= !prot_mode_r || can_io_privilege_field;
                fault_r.valid  <= prot_mode_r && !can_io_privilege_field && flags_r[`CBR_BIT_VM];
                fault_r.vector <= `CBR_VEC_GP;
                fault_err_r    <= `CBR_ERR_ALIGN;
            end else if (op == cbr_pkg::CBR_OP_SYSREG) begin
                sys_ok_r       <= cpl_r == `CBR_CPL_SYS && !v86_active_o;
                fault_r.valid  <= cpl_r != `CBR_CPL_SYS || v86_active_o;
                fault_r.vector <= `CBR_VEC_GP;
                fault_err_r    <= `CBR_ERR_ALIGN;
            end
        end
    end

    // Mode outputs held in flip-flops.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            v86_active_o     <= 1'b0;
            debug_suppress_o <= 1'b0;
        end else if (clk_en_i) begin
            v86_active_o     <= prot_mode_r && flags_r[`CBR_BIT_VM];
            debug_suppress_o <= flags_r[`CBR_BIT_RF];
        end
    end
    assign fault_valid_o  = fault_r.valid;
    assign fault_vector_o = fault_r.vector;
    assign fault_error_o  = fault_err_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: one-cycle registered answer.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_state_r  <= cbr_pkg::CBR_RD_IDLE;
            rdata_r     <= 32'h0000_0000;
            rresp_err_r <= 1'b0;
        end else if (clk_en_i) begin
            case (rd_state_r)
                cbr_pkg::CBR_RD_IDLE: begin
                    if (s_axi_arvalid && s_axi_arready) begin
                        rd_state_r  <= cbr_pkg::CBR_RD_RESP;
                        rresp_err_r <= 1'b0;
                        if (s_axi_araddr < `CBR_OFF_IP) begin
                            rdata_r <= gp_r[s_axi_araddr[4:2]];
                        end else begin
                            case (s_axi_araddr)
                                `CBR_OFF_IP:     rdata_r <= next_instruction_offset_r;
                                `CBR_OFF_FLAGS:  rdata_r <= flags_r;
                                `CBR_OFF_CTRL:   rdata_r <= {26'h0, ref_size_r, sys_ref_r,
                                                             prot_mode_r, cpl_r};
                                `CBR_OFF_STATUS: rdata_r <= {28'h0, sys_ok_r, io_ok_r,
                                                             debug_suppress_o, v86_active_o};
                                `CBR_OFF_CMD:    rdata_r <= result_r;
                                `CBR_OFF_IMAGE:  rdata_r <= image_r;
                                `CBR_OFF_ADDR:   rdata_r <= addr_r;
                                `CBR_OFF_FAULT:  rdata_r <= {23'h0, fault_r.valid, fault_r.vector};
                                default: begin
                                    rdata_r     <= 32'h0000_0000;
                                    rresp_err_r <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                cbr_pkg::CBR_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_r <= cbr_pkg::CBR_RD_IDLE;
                    end
                end
                default: rd_state_r <= cbr_pkg::CBR_RD_IDLE;
            endcase
        end
    end

    // Address ready registered; it is high only while idle.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
        end else if (clk_en_i) begin
            s_axi_arready <= (rd_state_r == cbr_pkg::CBR_RD_IDLE) && !s_axi_arvalid
                             || (rd_state_r == cbr_pkg::CBR_RD_RESP && s_axi_rready);
            s_axi_rvalid  <= (rd_state_r == cbr_pkg::CBR_RD_IDLE && s_axi_arvalid &&
                              s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
        end
    end
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_err_r ? `CBR_RESP_SLVERR : `CBR_RESP_OKAY;
endmodule : cbr_regfile

// [verilog/cbr_consts.svh]
// Constants for the base register file: offsets, field positions, vectors and reset values.
`ifndef CBR_CONSTS_SVH
`define CBR_CONSTS_SVH
`define CBR_OFF_GP0      12'h000
`define CBR_OFF_IP       12'h020
`define CBR_OFF_FLAGS    12'h024
`define CBR_OFF_CTRL     12'h028
`define CBR_OFF_STATUS   12'h02c
`define CBR_OFF_CMD      12'h030
`define CBR_OFF_IMAGE    12'h034
`define CBR_OFF_ADDR     12'h038
`define CBR_OFF_FAULT    12'h03c
`define CBR_BIT_ONE      1
`define CBR_BIT_IF       9
`define CBR_BIT_NT       14
`define CBR_BIT_RF       16
`define CBR_BIT_VM       17
`define CBR_BIT_AC       18
`define CBR_IO_PRIVILEGE_FIELD_LO      12
`define CBR_IO_PRIVILEGE_FIELD_HI      13
`define CBR_FLAGS_KEEP   32'h0007_7fd5
`define CBR_FLAGS_FORCE  32'h0000_0002
`define CBR_VEC_ALIGN    8'h11
`define CBR_VEC_GP       8'h0d
`define CBR_ERR_ALIGN    32'h0000_0000
`define CBR_CPL_USER     2'h3
`define CBR_CPL_SYS      2'h0
`define CBR_RESP_OKAY    2'h0
`define CBR_RESP_SLVERR  2'h2
`endif

// [verilog/cbr_pkg.sv]
// Types shared by the base register file.
package cbr_pkg;
    typedef enum logic [3:0] {
        CBR_OP_NONE, CBR_OP_GP32, CBR_OP_GP16, CBR_OP_GP8L, CBR_OP_GP8H,
        CBR_OP_PUSH_FLAGS_INSTR, CBR_OP_INTSAVE, CBR_OP_POP_FLAGS_INSTR, CBR_OP_INTERRUPT_RETURN_INSTR, CBR_OP_TASKSW,
        CBR_OP_RETIRE, CBR_OP_MEMREF, CBR_OP_IOCHK, CBR_OP_SYSREG, CBR_OP_SETIP
    } cbr_op_t;
    typedef enum logic [1:0] {CBR_SZ_BYTE, CBR_SZ_WORD, CBR_SZ_DWORD, CBR_SZ_QWORD} cbr_size_t;
    typedef struct packed {
        logic [7:0] vector;
        logic       valid;
    } cbr_fault_t;
    typedef enum {CBR_RD_IDLE, CBR_RD_RESP} cbr_rd_state_t;
endpackage : cbr_pkg

// [tb/cbr_regfile_assertions.sv]
// Bus and fault-report assertions for the base register file.
`timescale 1ns/1ps
module cbr_regfile_checker (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        clk_en_i,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        fault_valid_o,
    input wire logic [7:0]  fault_vector_o,
    input wire logic [31:0] fault_error_o
);
    ////////////////////////////////////////
    // All checks run on the core clock and pause while reset is applied.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_error_zero: assert property (fault_error_o == 32'h0)
        else $error("fault error code not zero");
    a_fault_vector: assert property (fault_valid_o |-> fault_vector_o inside {8'h11, 8'h0d})
        else $error("fault vector unknown");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en_i |=>
        s_axi_rvalid)
        else $error("read answer late");
    a_bresp_codes: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code bad");
    a_rresp_codes: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("read response code bad");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    c_align: cover property (fault_valid_o && fault_vector_o == 8'h11);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : cbr_regfile_checker
bind cbr_regfile cbr_regfile_checker u_chk (.*);

// [tb/test_cbr_regfile.sv]
// Self-checking bench for the base register file.
`timescale 1ns/1ps
`include "cbr_consts.svh"
module test_cbr_regfile;
    logic        core_clk_i, rstn_i, clk_en_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, v86_active_o, debug_suppress_o, fault_valid_o;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, fault_error_o, rd_v, fw, nw, e, b, v, ea;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, c, sz;
    logic [7:0]  fault_vector_o;
    logic [2:0]  r;
    logic        t;
    int          bad_count, n_checks;
    cbr_regfile u_dut (.*);
    ////////////////////////////////////////
    // A 100 ns core clock.
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task stop_test;
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // Writes offer address and data together and release each once taken.
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
    endtask : wr
    task rd(input logic [11:0] a, input logic [1:0] rs);
        @(posedge core_clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, rs});
    endtask : rd
    function logic [31:0] cmd(input cbr_pkg::cbr_op_t op, input logic [2:0] rg);
        return {25'h0, rg, op};
    endfunction : cmd
    function logic [31:0] fl(input logic [31:0] x);
        return (x & `CBR_FLAGS_KEEP) | `CBR_FLAGS_FORCE;
    endfunction : fl
    function logic mis(input logic [1:0] s, input logic [2:0] a);
        return (s == cbr_pkg::CBR_SZ_WORD && a[0]) || (s == cbr_pkg::CBR_SZ_DWORD && a[1:0] != 0)
            || (s == cbr_pkg::CBR_SZ_QWORD && a != 0);
    endfunction : mis
    ////////////////////////////////////////
    // Watchdog cuts a hung run short.
    initial begin
        #(100 * 20000);
        bad_count++;
        stop_test();
    end
    // Main sequence: register views, instruction pointer, then random flag and fault cases.
    initial begin
        {rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        clk_en_i = 1'b1;
        s_axi_wstrb = 4'hf;
        bad_count = 0;
        n_checks = 0;
        void'($urandom(32'h7a48));
        repeat (10) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rd(`CBR_OFF_FLAGS, 2'h0);
        chk("flags reset", rd_v, 32'h2);
        rd(12'h100, 2'h2);
        chk("unmapped", rd_v, 32'h0);
        for (int i = 0; i < 8; i++) begin
            r = 3'(i);
            b = $urandom();
            v = $urandom();
            wr({7'h0, r, 2'h0}, b);
            wr(`CBR_OFF_IMAGE, v);
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_GP16, r));
            rd({7'h0, r, 2'h0}, 2'h0);
            chk("gp16", rd_v, {b[31:16], v[15:0]});
            // Byte views exist only on the first four registers; the rest must not move.
            ea = {16'h0, v[31:16]};
            wr(`CBR_OFF_IMAGE, ea);
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_GP8L, r));
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_GP8H, r));
            rd({7'h0, r, 2'h0}, 2'h0);
            chk("gp8", rd_v, {b[31:16], (i < 4) ? {2{ea[7:0]}} : v[15:0]});
        end
        wr(`CBR_OFF_ADDR, v);
        wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_SETIP, 3'h0));
        rd(`CBR_OFF_IP, 2'h0);
        chk("ip", rd_v, v);
        for (int i = 0; i < 16; i++) begin
            {c, sz, t, fw, ea} = 69'({$urandom(), $urandom(), $urandom()});
            if (i < 6) {c, t, fw[18]} = 4'hd;
            wr(`CBR_OFF_CTRL, 32'h0);
            wr(`CBR_OFF_FLAGS, fw);
            fw = fl(fw);
            rd(`CBR_OFF_FLAGS, 2'h0);
            chk("flags", rd_v, fw);
            wr(`CBR_OFF_CTRL, {26'h0, sz, t, 1'b1, c});
            wr(`CBR_OFF_ADDR, ea);
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_MEMREF, 3'h0));
            rd(`CBR_OFF_FAULT, 2'h0);
            e = (fw[18] && c == 2'h3 && !t && mis(sz, ea[2:0])) ? 32'h111 : 32'h0;
            chk("fault", {23'h0, rd_v[8], rd_v[7:0] & {8{rd_v[8]}}}, e);
            chk("fault pin", {31'h0, fault_valid_o}, {31'h0, e[8]});
            chk("fault vec pin", {24'h0, fault_vector_o}, {24'h0, `CBR_VEC_ALIGN});
            chk("fault err pin", fault_error_o, `CBR_ERR_ALIGN);
            chk("v86 pin", {31'h0, v86_active_o}, {31'h0, fw[17]});
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_IOCHK, 3'h0));
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_SYSREG, 3'h0));
            rd(`CBR_OFF_STATUS, 2'h0);
            chk("io sys", {30'h0, rd_v[3:2]}, {30'h0, c == 2'h0 && !fw[17], c <= fw[13:12]});
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_PUSH_FLAGS_INSTR, 3'h0));
            rd(`CBR_OFF_CMD, 2'h0);
            chk("push_flags_instr", rd_v, fw & ~32'h2_0000);
            nw = $urandom();
            wr(`CBR_OFF_IMAGE, nw);
            // A random bit picks interrupt return or pop-flags; only the former may load v86.
            wr(`CBR_OFF_CMD, cmd(ea[3] ? cbr_pkg::CBR_OP_INTERRUPT_RETURN_INSTR : cbr_pkg::CBR_OP_POP_FLAGS_INSTR, 3'h0));
            rd(`CBR_OFF_FLAGS, 2'h0);
            e = fl(nw);
            if (!ea[3] || c != 2'h0) e[17] = fw[17];
            if (c != 2'h0) e[13:12] = fw[13:12];
            if (c > fw[13:12]) e[9] = fw[9];
            chk("pop_flags_instr", rd_v, e);
            chk("suppress", {31'h0, debug_suppress_o}, {31'h0, e[16]});
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_RETIRE, 3'h0));
            rd(`CBR_OFF_FLAGS, 2'h0);
            chk("retire", rd_v, e & ~32'h1_0000);
            wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_INTSAVE, 3'h0));
            rd(`CBR_OFF_CMD, 2'h0);
            chk("intsave", rd_v, e & ~32'h1_0000);
        end
        // Task switch loads flags, pointer and one register, then a full-width write.
        nw = $urandom();
        wr(`CBR_OFF_IMAGE, nw);
        wr(`CBR_OFF_ADDR, ea);
        wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_TASKSW, 3'h5));
        rd(`CBR_OFF_FLAGS, 2'h0);
        chk("task flags", rd_v, fl(nw));
        rd(`CBR_OFF_IP, 2'h0);
        chk("task ip", rd_v, ea);
        rd({7'h0, 3'h5, 2'h0}, 2'h0);
        chk("task gp", rd_v, nw);
        wr(`CBR_OFF_CMD, cmd(cbr_pkg::CBR_OP_GP32, 3'h2));
        rd({7'h0, 3'h2, 2'h0}, 2'h0);
        chk("gp32", rd_v, nw);
        stop_test();
    end
endmodule : test_cbr_regfile
